//--- line_sense_pkg.sv
// Shared constants for the power line carrier sense and transmit level block
package line_sense_pkg;
   // Preamble symbols needed before the line is reported busy
   localparam logic [3:0] SLOT_PREAMBLE_COUNT = 4'h3;
   // Width of the preamble symbol counter
   localparam int SENSE_CNT_W = 4;
   // Transmit level reduction field, in dB
   localparam int REDUCTION_W = 5;
   // Largest reduction the output stage can apply, in dB
   localparam logic [4:0] MAX_REDUCTION_DB = 5'h19;
   // No reduction configured
   localparam logic [4:0] ZERO_REDUCTION = 5'h00;
   // Level raise used when repeating a decoded frame, in dB
   localparam logic [4:0] REPEAT_RAISE_DB = 5'h06;
   // Per-neighbour transmit gain field width
   localparam int BOOST_W = 4;
   // Spectral shaping coefficient field width
   localparam int SHAPE_W = 8;
   // Reset values of the applied transmit settings
   localparam logic [3:0] BOOST_RESET = 4'h0;
   localparam logic [7:0] SHAPE_RESET = 8'h00;
   // Symbol time and the clock that paces it
   localparam int SYMBOL_TIME_NS = 640000;
   localparam int CLOCK_PERIOD_NS = 50;
   localparam int SYMBOL_CYCLES = SYMBOL_TIME_NS / CLOCK_PERIOD_NS;
   // Carrier phase accumulator width and step per clock
   localparam int PHASE_W = 16;
   localparam logic [15:0] CARRIER_STEP = 16'h1000;
   localparam logic [15:0] PHASE_RESET = 16'h0000;
   // Symbol divider width
   localparam int DIV_W = 16;
   localparam logic [15:0] DIV_RESET = 16'h0000;
   // Carrier sense states
   typedef enum logic [2:0] {
      SENSE_IDLE = 3'h1,
      SENSE_HUNT = 3'h2,
      SENSE_BUSY = 3'h4
   } sense_state_t;
endpackage : line_sense_pkg

//--- symbol_clock_gen.sv
// Symbol tick and carrier phase generated from the one system clock
`timescale 1ns/1ps
`default_nettype none
module symbol_clock_gen #(
   parameter int SYMBOL_CYCLES = line_sense_pkg::SYMBOL_CYCLES
) (
   // Clock and reset
   input wire logic clk,
   input wire logic arst_n,
   // Timing outputs
   output logic symbol_tick,
   output logic [line_sense_pkg::PHASE_W-1:0] carrier_phase
);
   // Cycles counted within the current symbol
   logic [line_sense_pkg::DIV_W-1:0] div_count;
   // Last count of a symbol, cut to the divider width
   localparam logic [15:0] DIV_LAST = 16'(SYMBOL_CYCLES - 1);

   // Symbol divider, paced by the system clock
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         div_count <= line_sense_pkg::DIV_RESET;
         symbol_tick <= 1'b0;
      end else if (div_count == DIV_LAST) begin
         div_count <= line_sense_pkg::DIV_RESET;
         symbol_tick <= 1'b1;
      end else begin
         div_count <= div_count + 16'h0001;
         symbol_tick <= 1'b0;
      end
   end

   // Carrier phase accumulator on the same clock as the symbol divider
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         carrier_phase <= line_sense_pkg::PHASE_RESET;
      end else begin
         carrier_phase <= carrier_phase + line_sense_pkg::CARRIER_STEP;
      end
   end
endmodule : symbol_clock_gen
`default_nettype wire

//--- line_sense_tx_level.sv
// Carrier sense reply and transmit level selection for a power line PHY
//
// Overview of operation
// - Each query answered with idle or busy
// - Sense goes busy after slot preamble count
// - Sense returns idle when synchronisation fails
// - Output level reduced by setting, up to 25 dB
// - Nonzero reduction ignores per-neighbour transmit boost
// - Carrier and symbol timing share one clock
// - Flatness test forces boost and shaping zero
// - Repeater re-sends decoded frames at raised level
`timescale 1ns/1ps
`default_nettype none
module line_sense_tx_level #(
   parameter int SYMBOL_CYCLES = line_sense_pkg::SYMBOL_CYCLES
) (
   // Clock and reset
   input wire logic SYS_CLK,
   input wire logic ARST_N,
   // Media status query and reply
   input wire logic MEDIA_STATUS_QUERY,
   output logic MEDIA_STATUS_REPLY,
   output logic MEDIA_STATUS_BUSY,
   // Receiver events
   input wire logic PREAMBLE_SYMBOL,
   input wire logic SYNC_ACHIEVED,
   input wire logic SYNC_FAILED,
   input wire logic RX_FRAME_END,
   input wire logic RX_FRAME_DECODED,
   // Carrier sense state
   output logic PHYSICAL_LINE_SENSE,
   // Transmit configuration
   input wire logic [line_sense_pkg::REDUCTION_W-1:0] TX_LEVEL_REDUCTION,
   input wire logic [line_sense_pkg::BOOST_W-1:0] TX_BOOST_SETTING,
   input wire logic [line_sense_pkg::SHAPE_W-1:0] TX_SPECTRAL_SHAPE,
   input wire logic FLATNESS_TEST,
   input wire logic REPEATER_MODE,
   input wire logic TX_DONE,
   // Applied transmit settings
   output logic [line_sense_pkg::REDUCTION_W-1:0] TX_REDUCTION_APPLIED,
   output logic [line_sense_pkg::BOOST_W-1:0] TX_BOOST_APPLIED,
   output logic [line_sense_pkg::SHAPE_W-1:0] TX_SHAPE_APPLIED,
   // Repeater request
   output logic REPEAT_REQUEST,
   output logic REPEAT_ACTIVE,
   // Timing from the system clock
   output logic SYMBOL_TICK,
   output logic [line_sense_pkg::PHASE_W-1:0] CARRIER_PHASE
);
   // Carrier sense state machine
   line_sense_pkg::sense_state_t sense_state;
   // Preamble symbols seen in the current hunt
   logic [line_sense_pkg::SENSE_CNT_W-1:0] preamble_count;
   // Reduction clamped to the supported range
   logic [line_sense_pkg::REDUCTION_W-1:0] clamped_reduction;
   // Reduction after the repeater raise
   logic [line_sense_pkg::REDUCTION_W-1:0] next_reduction;
   // Boost and shaping to apply next
   logic [line_sense_pkg::BOOST_W-1:0] next_boost;
   logic [line_sense_pkg::SHAPE_W-1:0] next_shape;
   // Timing from the divider module
   logic symbol_tick_int;
   logic [line_sense_pkg::PHASE_W-1:0] carrier_phase_int;

   // Symbol and carrier timing from the same clock
   symbol_clock_gen #(
      .SYMBOL_CYCLES(SYMBOL_CYCLES)
   ) timing (
      .clk(SYS_CLK),
      .arst_n(ARST_N),
      .symbol_tick(symbol_tick_int),
      .carrier_phase(carrier_phase_int)
   );

   // Register the timing outputs
   always_ff @(posedge SYS_CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         SYMBOL_TICK <= 1'b0;
         CARRIER_PHASE <= line_sense_pkg::PHASE_RESET;
      end else begin
         SYMBOL_TICK <= symbol_tick_int;
         CARRIER_PHASE <= carrier_phase_int;
      end
   end

   // Carrier sense: hunt for preamble, go busy, drop on lost sync
   always_ff @(posedge SYS_CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         sense_state <= line_sense_pkg::SENSE_IDLE;
         preamble_count <= '0;
      end else begin
         case (sense_state)
            // Waiting for the first preamble symbol
            line_sense_pkg::SENSE_IDLE: begin
               if (PREAMBLE_SYMBOL) begin
                  preamble_count <= 4'h1;
                  if (line_sense_pkg::SLOT_PREAMBLE_COUNT == 4'h1) begin
                     sense_state <= line_sense_pkg::SENSE_BUSY;
                  end else begin
                     sense_state <= line_sense_pkg::SENSE_HUNT;
                  end
               end
            end
            // Counting preamble symbols
            line_sense_pkg::SENSE_HUNT: begin
               if (SYNC_FAILED) begin
                  sense_state <= line_sense_pkg::SENSE_IDLE;
                  preamble_count <= '0;
               end else if (PREAMBLE_SYMBOL) begin
                  preamble_count <= preamble_count + 4'h1;
                  if (preamble_count + 4'h1 >= line_sense_pkg::SLOT_PREAMBLE_COUNT) begin
                     sense_state <= line_sense_pkg::SENSE_BUSY;
                  end
               end
            end
            // Line reported busy until sync fails or frame ends
            line_sense_pkg::SENSE_BUSY: begin
               if (SYNC_FAILED || RX_FRAME_END) begin
                  sense_state <= line_sense_pkg::SENSE_IDLE;
                  preamble_count <= '0;
               end
            end
            // Recover from an illegal code
            default: begin
               sense_state <= line_sense_pkg::SENSE_IDLE;
               preamble_count <= '0;
            end
         endcase
      end
   end

   // Physical sense output follows the busy state
   always_ff @(posedge SYS_CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         PHYSICAL_LINE_SENSE <= 1'b0;
      end else begin
         PHYSICAL_LINE_SENSE <= (sense_state == line_sense_pkg::SENSE_BUSY);
      end
   end

   // One reply per query, status sampled from the sense state
   always_ff @(posedge SYS_CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         MEDIA_STATUS_REPLY <= 1'b0;
         MEDIA_STATUS_BUSY <= 1'b0;
      end else begin
         MEDIA_STATUS_REPLY <= MEDIA_STATUS_QUERY;
         if (MEDIA_STATUS_QUERY) begin
            // Busy is 1, idle is 0
            MEDIA_STATUS_BUSY <= (sense_state == line_sense_pkg::SENSE_BUSY);
         end
      end
   end

   // Repeater: a decoded frame launches a raised-level retransmission
   always_ff @(posedge SYS_CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         REPEAT_REQUEST <= 1'b0;
         REPEAT_ACTIVE <= 1'b0;
      end else begin
         REPEAT_REQUEST <= REPEATER_MODE && RX_FRAME_DECODED && !REPEAT_ACTIVE;
         if (REPEATER_MODE && RX_FRAME_DECODED && !REPEAT_ACTIVE) begin
            REPEAT_ACTIVE <= 1'b1;
         end else if (TX_DONE || !REPEATER_MODE) begin
            REPEAT_ACTIVE <= 1'b0;
         end
      end
   end

   // Choose reduction, boost and shaping for the next transmission
   always_comb begin
      // Clamp the setting to the supported range
      if (TX_LEVEL_REDUCTION > line_sense_pkg::MAX_REDUCTION_DB) begin
         clamped_reduction = line_sense_pkg::MAX_REDUCTION_DB;
      end else begin
         clamped_reduction = TX_LEVEL_REDUCTION;
      end
      // Repeated frames go out louder, saturating at full level
      if (REPEAT_ACTIVE) begin
         if (clamped_reduction > line_sense_pkg::REPEAT_RAISE_DB) begin
            next_reduction = clamped_reduction - line_sense_pkg::REPEAT_RAISE_DB;
         end else begin
            next_reduction = line_sense_pkg::ZERO_REDUCTION;
         end
      end else begin
         next_reduction = clamped_reduction;
      end
      // Neighbour boost only when no reduction is configured
      if (FLATNESS_TEST) begin
         next_boost = line_sense_pkg::BOOST_RESET;
         next_shape = line_sense_pkg::SHAPE_RESET;
      end else if (TX_LEVEL_REDUCTION != line_sense_pkg::ZERO_REDUCTION) begin
         next_boost = line_sense_pkg::BOOST_RESET;
         next_shape = TX_SPECTRAL_SHAPE;
      end else begin
         next_boost = TX_BOOST_SETTING;
         next_shape = TX_SPECTRAL_SHAPE;
      end
   end

   // Register the applied transmit settings
   always_ff @(posedge SYS_CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         TX_REDUCTION_APPLIED <= line_sense_pkg::ZERO_REDUCTION;
         TX_BOOST_APPLIED <= line_sense_pkg::BOOST_RESET;
         TX_SHAPE_APPLIED <= line_sense_pkg::SHAPE_RESET;
      end else begin
         TX_REDUCTION_APPLIED <= next_reduction;
         TX_BOOST_APPLIED <= next_boost;
         TX_SHAPE_APPLIED <= next_shape;
      end
   end

   // Sync achieved keeps the busy state; only failure ends it early
   logic unused_sync;
   assign unused_sync = SYNC_ACHIEVED;
endmodule : line_sense_tx_level
`default_nettype wire

//--- line_sense_sva.sv
// Concurrent checks on the carrier sense and transmit level ports
`timescale 1ns/1ps
`default_nettype none
module line_sense_sva #(
   parameter int SYMBOL_CYCLES = 8
) (
   // Clock, reset, query and sense
   input wire logic SYS_CLK,
   input wire logic ARST_N,
   input wire logic MEDIA_STATUS_QUERY,
   input wire logic MEDIA_STATUS_REPLY,
   input wire logic MEDIA_STATUS_BUSY,
   input wire logic PREAMBLE_SYMBOL,
   input wire logic SYNC_FAILED,
   input wire logic RX_FRAME_END,
   input wire logic PHYSICAL_LINE_SENSE,
   // Transmit settings, repeater and timing
   input wire logic [4:0] TX_LEVEL_REDUCTION,
   input wire logic FLATNESS_TEST,
   input wire logic REPEATER_MODE,
   input wire logic RX_FRAME_DECODED,
   input wire logic [4:0] TX_REDUCTION_APPLIED,
   input wire logic [3:0] TX_BOOST_APPLIED,
   input wire logic [7:0] TX_SHAPE_APPLIED,
   input wire logic REPEAT_REQUEST,
   input wire logic REPEAT_ACTIVE,
   input wire logic SYMBOL_TICK
);
   default clocking cb @(posedge SYS_CLK); endclocking
   default disable iff (!ARST_N);
   // Clamped reduction and cycles since the last tick
   logic [4:0] lim;
   // Signed so it can start behind the divider and output register latency
   int gap;
   assign lim = (TX_LEVEL_REDUCTION > 5'h19) ? 5'h19 : TX_LEVEL_REDUCTION;
   // Tick spacing counter; first tick after reset lands two edges later
   always_ff @(posedge SYS_CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         gap <= -2;
      end else begin
         gap <= SYMBOL_TICK ? 0 : gap + 1;
      end
   end
   // Three clean preamble symbols; a decoded frame taken for repeat
   sequence s_pre3;
      (PREAMBLE_SYMBOL && !SYNC_FAILED && !RX_FRAME_END)[*3];
   endsequence
   sequence s_take;
      REPEATER_MODE && RX_FRAME_DECODED && !REPEAT_ACTIVE;
   endsequence
   a_reply_follows:
      assert property (MEDIA_STATUS_QUERY |=> MEDIA_STATUS_REPLY) else $error("no reply");
   a_reply_cause:
      assert property (MEDIA_STATUS_REPLY |-> $past(MEDIA_STATUS_QUERY)) else $error("extra reply");
   a_busy_is_sense:
      assert property (MEDIA_STATUS_REPLY |-> MEDIA_STATUS_BUSY == PHYSICAL_LINE_SENSE)
      else $error("reply status wrong");
   a_sense_rises:
      assert property (s_pre3 |-> ##2 PHYSICAL_LINE_SENSE) else $error("sense not raised");
   a_sense_falls:
      assert property ((SYNC_FAILED || (RX_FRAME_END && !PREAMBLE_SYMBOL))
         |-> ##2 !PHYSICAL_LINE_SENSE) else $error("sense not dropped");
   a_boost_ignored:
      assert property ((TX_LEVEL_REDUCTION != 5'h00 || FLATNESS_TEST)
         |=> TX_BOOST_APPLIED == 4'h0) else $error("boost applied");
   a_shape_flat:
      assert property (FLATNESS_TEST |=> TX_SHAPE_APPLIED == 8'h00) else $error("shape applied");
   a_level_follows:
      assert property (!REPEAT_ACTIVE |=> TX_REDUCTION_APPLIED == $past(lim))
      else $error("reduction wrong");
   a_repeat_raise:
      assert property (REPEAT_ACTIVE |=> TX_REDUCTION_APPLIED ==
         (($past(lim) > 5'h06) ? $past(lim) - 5'h06 : 5'h00)) else $error("repeat level wrong");
   a_repeat_start:
      assert property (s_take |=> REPEAT_REQUEST && REPEAT_ACTIVE) else $error("repeat not begun");
   a_tick_not_late:
      assert property (gap < SYMBOL_CYCLES) else $error("symbol tick late");
   a_tick_spacing:
      assert property (SYMBOL_TICK |-> gap == SYMBOL_CYCLES - 1) else $error("symbol tick early");
endmodule : line_sense_sva
`default_nettype wire

//--- mac_mgmt_model.sv
// MAC side model issuing media status queries
`timescale 1ns/1ps
`default_nettype none
module mac_mgmt_model (
   // Clock, reset and bench command
   input wire logic clk,
   input wire logic arst_n,
   input wire logic ask,
   // Query out, reply in
   output logic query,
   input wire logic reply,
   input wire logic busy,
   // Occupancy as last reported
   output logic virtual_line_sense
);
   // Parameterless one-cycle query
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         query <= 1'b0;
      end else begin
         query <= ask;
      end
   end
   // Own occupancy view, updated by each reply
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         virtual_line_sense <= 1'b0;
      end else if (reply) begin
         virtual_line_sense <= busy;
      end
   end
endmodule : mac_mgmt_model
`default_nettype wire

//--- tb_line_sense_tx_level.sv
// Bench for carrier sense reply and transmit level selection
`timescale 1ns/1ps
`default_nettype none
module tb_line_sense_tx_level;
   // Stimulus
   logic SYS_CLK = 1'b0, ARST_N = 1'b0, ask = 1'b0, pre = 1'b0, sfail = 1'b0, fend = 1'b0;
   logic dec = 1'b0, flat = 1'b0, rmode = 1'b0, done = 1'b0;
   logic [4:0] red = 5'h00;
   logic [3:0] boost = 4'h0;
   logic [7:0] shape = 8'h00;
   // Observed outputs
   logic query, reply, busy, sense, req, act, tick, vls;
   logic [4:0] red_ap;
   logic [3:0] boost_ap;
   logic [7:0] shape_ap;
   logic [15:0] phase;
   int error_cnt = 0, checks = 0, cyc = 0;
   line_sense_tx_level #(.SYMBOL_CYCLES(8)) dut_u (.SYS_CLK(SYS_CLK), .ARST_N(ARST_N),
      .MEDIA_STATUS_QUERY(query), .MEDIA_STATUS_REPLY(reply), .MEDIA_STATUS_BUSY(busy),
      .PREAMBLE_SYMBOL(pre), .SYNC_ACHIEVED(1'b0), .SYNC_FAILED(sfail), .RX_FRAME_END(fend),
      .RX_FRAME_DECODED(dec), .PHYSICAL_LINE_SENSE(sense), .TX_LEVEL_REDUCTION(red),
      .TX_BOOST_SETTING(boost), .TX_SPECTRAL_SHAPE(shape), .FLATNESS_TEST(flat),
      .REPEATER_MODE(rmode), .TX_DONE(done), .TX_REDUCTION_APPLIED(red_ap),
      .TX_BOOST_APPLIED(boost_ap), .TX_SHAPE_APPLIED(shape_ap), .REPEAT_REQUEST(req),
      .REPEAT_ACTIVE(act), .SYMBOL_TICK(tick), .CARRIER_PHASE(phase));
   mac_mgmt_model mac_u (.clk(SYS_CLK), .arst_n(ARST_N), .ask(ask), .query(query),
      .reply(reply), .busy(busy), .virtual_line_sense(vls));
   // Clock and hang guard
   initial begin
      forever #25 SYS_CLK = ~SYS_CLK;
   end
   always @(posedge SYS_CLK) begin
      cyc++;
      if (cyc == 3000) begin
         error_cnt++;
         end_sim();
      end
   end
   // Step n clocks, landing just after the edge
   task tk(input int n);
      repeat (n) begin
         @(posedge SYS_CLK);
         #1;
      end
   endtask : tk
   // Compare and report
   task chk(input logic [15:0] seen, input logic [15:0] exp);
      checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   // One query; reply for exactly one cycle with the status
   task ask_status(input logic exp);
      ask = 1'b1;
      tk(1);
      ask = 1'b0;
      tk(1);
      chk(reply, 1'b1);
      chk(busy, exp);
      tk(1);
      chk(reply, 1'b0);
      chk(vls, exp);
   endtask : ask_status
   // Two symbols stay idle, three go busy, then fail and frame end drop it
   task t_sense;
      pre = 1'b1;
      tk(2);
      pre = 1'b0;
      sfail = 1'b1;
      tk(1);
      sfail = 1'b0;
      tk(2);
      chk(sense, 1'b0);
      ask_status(1'b0);
      pre = 1'b1;
      tk(3);
      pre = 1'b0;
      tk(2);
      chk(sense, 1'b1);
      ask_status(1'b1);
      sfail = 1'b1;
      tk(1);
      sfail = 1'b0;
      tk(2);
      chk(sense, 1'b0);
      pre = 1'b1;
      tk(3);
      pre = 1'b0;
      fend = 1'b1;
      tk(1);
      chk(sense, 1'b1);
      fend = 1'b0;
      tk(3);
      chk(sense, 1'b0);
   endtask : t_sense
   // Reduction, boost suppression, clamp and flatness test
   task t_level;
      red = 5'h04;
      boost = 4'h5;
      shape = 8'hA5;
      tk(2);
      chk(red_ap, 5'h04);
      chk(boost_ap, 4'h0);
      chk(shape_ap, 8'hA5);
      red = 5'h00;
      tk(2);
      chk(boost_ap, 4'h5);
      red = 5'h1F;
      tk(2);
      chk(red_ap, line_sense_pkg::MAX_REDUCTION_DB);
      red = 5'h00;
      flat = 1'b1;
      tk(2);
      chk({boost_ap, shape_ap}, 12'h000);
      flat = 1'b0;
   endtask : t_level
   // Repeat start, refused second frame, raised level, finish
   task t_repeat;
      red = 5'h0A;
      rmode = 1'b1;
      dec = 1'b1;
      tk(1);
      chk({req, act}, 2'h3);
      tk(1);
      dec = 1'b0;
      chk({req, act}, 2'h1);
      chk(red_ap, 5'h0A - line_sense_pkg::REPEAT_RAISE_DB);
      done = 1'b1;
      tk(1);
      done = 1'b0;
      chk(act, 1'b0);
      rmode = 1'b0;
   endtask : t_repeat
   // Symbol tick spacing and carrier step from the one clock
   task t_tick;
      int n;
      logic [15:0] p;
      for (n = 0; n < 20 && tick !== 1'b1; n++) tk(1);
      tk(1);
      for (n = 1; n < 20 && tick !== 1'b1; n++) tk(1);
      chk(n, 8);
      p = phase;
      tk(1);
      chk(phase, p + line_sense_pkg::CARRIER_STEP);
   endtask : t_tick
   // Verdict and stop
   task end_sim;
      $display("error_cnt %0d checks %0d", error_cnt, checks);
      if (error_cnt == 0 && checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : end_sim
   // Main sequence
   initial begin
      repeat (16) @(posedge SYS_CLK);
      #1 ARST_N = 1'b1;
      tk(2);
      t_level();
      t_sense();
      t_repeat();
      t_tick();
      end_sim();
   end
endmodule : tb_line_sense_tx_level
bind line_sense_tx_level line_sense_sva #(.SYMBOL_CYCLES(SYMBOL_CYCLES)) sva_u (.SYS_CLK,
   .ARST_N, .MEDIA_STATUS_QUERY, .MEDIA_STATUS_REPLY, .MEDIA_STATUS_BUSY, .PREAMBLE_SYMBOL,
   .SYNC_FAILED, .RX_FRAME_END, .PHYSICAL_LINE_SENSE, .TX_LEVEL_REDUCTION, .FLATNESS_TEST,
   .REPEATER_MODE, .RX_FRAME_DECODED, .TX_REDUCTION_APPLIED, .TX_BOOST_APPLIED,
   .TX_SHAPE_APPLIED, .REPEAT_REQUEST, .REPEAT_ACTIVE, .SYMBOL_TICK);
`default_nettype wire
